// *** port_reset_pkg.sv ***
// constants and types shared by the downstream port reset sequencer
`default_nettype none
package port_reset_pkg;
  // register bus geometry
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  // register offsets (byte addresses)
  localparam logic [7:0] BRIDGE_CTL_OFS  = 8'h00;
  localparam logic [7:0] SWITCH_CTL_OFS  = 8'h04;
  localparam logic [7:0] SLOT_CTL_OFS    = 8'h08;
  localparam logic [7:0] HP_CFG_OFS      = 8'h0c;
  localparam logic [7:0] STATUS_OFS      = 8'h10;
  // bridge control: downstream secondary bus reset bit
  localparam int unsigned SBR_BIT        = 0;
  // switch control: upstream secondary bus reset bit
  localparam int unsigned UP_SBR_BIT     = 0;
  // slot control: power off control bit, set means power off
  localparam int unsigned PWR_OFF_BIT    = 0;
  localparam logic PWR_OFF_RST           = 1'b1;
  // hot plug configuration fields
  localparam int unsigned MODE_LSB       = 0;
  localparam int unsigned MODE_W         = 2;
  localparam int unsigned P2R_LSB        = 8;
  localparam int unsigned R2P_LSB        = 16;
  localparam int unsigned DLY_W          = 8;
  localparam int unsigned RST_OE_BIT     = 24;
  localparam logic [1:0] MODE_RST        = 2'h0;
  localparam logic [7:0] P2R_RST         = 8'h0a;
  localparam logic [7:0] R2P_RST         = 8'h0a;
  // status fields
  localparam int unsigned ST_SBR_BIT     = 0;
  localparam int unsigned ST_RST_BIT     = 1;
  localparam int unsigned ST_PE_BIT      = 2;
  localparam int unsigned ST_PG_BIT      = 3;
  localparam int unsigned ST_LINK_BIT    = 4;
  localparam int unsigned ST_BUSY_BIT    = 5;
  // timing: delay fields count microseconds
  localparam int unsigned CLK_PERIOD_NS  = 20;
  localparam int unsigned US_NS          = 1000;
  localparam int unsigned US_CYCLES      = US_NS / CLK_PERIOD_NS;
  localparam int unsigned MIN_PULSE_US   = 200;
  localparam int unsigned MIN_PULSE_CYC  =
    (MIN_PULSE_US * US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned TMR_W          = 16;
  // reset output modes
  typedef enum logic [1:0] {
    MODE_PWR_EN  = 2'h0,
    MODE_PWR_GD  = 2'h1,
    MODE_HOT_RST = 2'h2
  } rst_mode_t;
endpackage
`default_nettype wire

// *** pin_sync.sv ***
// two-flop synchroniser for a pin level
`default_nettype none
module pin_sync #(
  parameter logic RST_VAL = 1'b0
) (
  // clock and reset
  input  wire logic clock,
  input  wire logic rst,
  // asynchronous level in, synchronised level out
  input  wire logic async_in,
  output var  logic sync_out
);
  typedef struct packed {
    logic meta;
    logic sync;
  } sync_state_t;

  sync_state_t s_q;
  sync_state_t s_d;

  // first stage feeds only the second
  always_comb begin
    s_d      = s_q;
    s_d.meta = async_in;
    s_d.sync = s_q.meta;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      s_q <= '{meta: RST_VAL, sync: RST_VAL};
    end else begin
      s_q <= s_d;
    end
  end

  assign sync_out = s_q.sync;
endmodule // pin_sync
`default_nettype wire

// *** interval_timer.sv ***
// loadable down counter; busy while counting ticks
`default_nettype none
module interval_timer #(
  parameter int unsigned W = 16
) (
  // clock and reset
  input  wire logic         clock,
  input  wire logic         rst,
  // control
  input  wire logic         start,
  input  wire logic [W-1:0] load_val,
  input  wire logic         tick,
  // state
  output var  logic         busy
);
  typedef struct packed {
    logic [W-1:0] cnt;
  } tmr_state_t;

  tmr_state_t s_q;
  tmr_state_t s_d;

  // load on start, else count down on each tick
  always_comb begin
    s_d = s_q;
    if (start) begin
      s_d.cnt = load_val;
    end else if (tick && s_q.cnt != '0) begin
      s_d.cnt = s_q.cnt - W'(1);
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      s_q <= '{cnt: '0};
    end else begin
      s_q <= s_d;
    end
  end

  assign busy = (s_q.cnt != '0);
endmodule // interval_timer
`default_nettype wire

// *** downstream_port_reset_sequencer.sv ***
// per downstream port reset and slot power sequencer
// Notes on behaviour
// - hot reset training sets go out only when the port link is up
// - queued packets received from this port are discarded on that reset
// - after flushing, wait for the upstream switch bit to clear, then resume
// - the reset touches only this port, never upstream or other ports
// - type 0 configuration to this port still completes during the reset
// - packets for the secondary side are unsupported requests meanwhile
// - the slave management bus keeps working throughout the reset
// - reset output pin is undriven after reset until software enables it
// - every reset output assertion after the one held from reset lasts at least 200 microseconds
// - a mode field picks power enable, power good or hot reset control
// - power enable mode: reset asserted with power off, negated with it on
// - power on: enable power first, negate reset after power-to-reset delay; hot reset mode turns power on at once, reset untouched
// - power off: assert reset first, drop power after reset-to-power delay; hot reset mode turns power off at once, reset untouched
// - power good mode: negate reset the delay after power good asserts
// - power good mode: power good loss asserts reset at once
//
// The address map and the address-and-strobe port were left to the implementer.
`default_nettype none
module downstream_port_reset_sequencer #(
  parameter int unsigned MIN_PULSE_CYCLES = port_reset_pkg::MIN_PULSE_CYC
) (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  // register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  output var  logic [31:0] reg_rdata,
  // link and queue side, same clock
  input  wire logic        link_up,
  input  wire logic        flush_done,
  output var  logic        send_hot_reset,
  output var  logic        flush_tlps,
  output var  logic        secondary_ur,
  // slot pins
  input  wire logic        slot_power_good_n,
  output var  logic        slot_power_enable_out,
  output var  logic        port_reset_out_n_o,
  output var  logic        port_reset_out_n_oe
);
  typedef enum logic [1:0] {
    SBR_IDLE,
    SBR_HOT,
    SBR_FLUSH,
    SBR_WAIT
  } sbr_st_t;

  typedef enum logic [2:0] {
    PWR_OFF,
    PWR_WAIT_GOOD,
    PWR_ON_DLY,
    PWR_ON,
    PWR_OFF_DLY
  } pwr_st_t;

  typedef struct packed {
    logic        bridge_sbr;
    logic        up_sbr;
    logic        pwr_off;
    logic [1:0]  mode;
    logic [7:0]  p2r;
    logic [7:0]  r2p;
    logic        rst_oe;
    sbr_st_t     sbr;
    pwr_st_t     pwr;
    logic [5:0]  pre;
    logic        us_tick;
    logic        dly_start;
    logic [7:0]  dly_val;
    logic        pulse_start;
    logic        rst_on;
    logic        rst_n;
    logic        pe;
    logic        hot;
    logic        flush;
    logic        ur;
    logic        oe;
    logic [31:0] rdata;
  } seq_state_t;

  seq_state_t s_q;
  seq_state_t s_d;
  logic       pg_n_sync;
  logic       dly_busy;
  logic       pulse_busy;
  logic       want_rst;

  // field read helper, used for every single-bit register field
  function automatic logic [31:0] put_bit(input logic v, input int unsigned p);
    put_bit = 32'h0000_0000;
    put_bit[p[4:0]] = v;
  endfunction

  // decode of a write to one register offset
  function automatic logic wr_hit(input logic [7:0] ofs);
    wr_hit = reg_write && (reg_addr == ofs);
  endfunction

  // power good pin arrives from outside the clock domain
  pin_sync #(
    .RST_VAL (1'b1)
  ) u_pg_sync (
    .clock    (clock),
    .rst      (rst),
    .async_in (slot_power_good_n),
    .sync_out (pg_n_sync)
  );

  // power-to-reset and reset-to-power delays in microseconds
  interval_timer #(
    .W (port_reset_pkg::DLY_W)
  ) u_dly_tmr (
    .clock    (clock),
    .rst      (rst),
    .start    (s_q.dly_start),
    .load_val (s_q.dly_val),
    .tick     (s_q.us_tick),
    .busy     (dly_busy)
  );

  // minimum reset pulse width in clock cycles
  interval_timer #(
    .W (port_reset_pkg::TMR_W)
  ) u_pulse_tmr (
    .clock    (clock),
    .rst      (rst),
    .start    (s_q.pulse_start),
    .load_val (port_reset_pkg::TMR_W'(MIN_PULSE_CYCLES)),
    .tick     (1'b1),
    .busy     (pulse_busy)
  );

  // reset wanted by the selected mode
  always_comb begin
    case (port_reset_pkg::rst_mode_t'(s_q.mode))
      port_reset_pkg::MODE_HOT_RST:
        want_rst = (s_q.sbr != SBR_IDLE);
      default:
        want_rst = (s_q.pwr != PWR_ON);
    endcase
  end

  // next state of all registers and sequencers
  always_comb begin
    s_d             = s_q;
    s_d.dly_start   = 1'b0;
    s_d.pulse_start = 1'b0;
    s_d.rdata       = 32'h0000_0000;

    // microsecond prescaler for the delay fields
    s_d.us_tick = 1'b0;
    if (s_q.pre == 6'(port_reset_pkg::US_CYCLES - 1)) begin
      s_d.pre     = 6'h00;
      s_d.us_tick = 1'b1;
    end else begin
      s_d.pre = s_q.pre + 6'h01;
    end

    // register writes
    if (wr_hit(port_reset_pkg::BRIDGE_CTL_OFS)) begin
      s_d.bridge_sbr = reg_wdata[port_reset_pkg::SBR_BIT];
    end
    if (wr_hit(port_reset_pkg::SWITCH_CTL_OFS)) begin
      s_d.up_sbr = reg_wdata[port_reset_pkg::UP_SBR_BIT];
    end
    if (wr_hit(port_reset_pkg::SLOT_CTL_OFS)) begin
      s_d.pwr_off = reg_wdata[port_reset_pkg::PWR_OFF_BIT];
    end
    if (wr_hit(port_reset_pkg::HP_CFG_OFS)) begin
      s_d.mode   = reg_wdata[port_reset_pkg::MODE_LSB +: 2];
      s_d.p2r    = reg_wdata[port_reset_pkg::P2R_LSB +: 8];
      s_d.r2p    = reg_wdata[port_reset_pkg::R2P_LSB +: 8];
      s_d.rst_oe = reg_wdata[port_reset_pkg::RST_OE_BIT];
    end

    // register reads, answered in the next cycle
    if (reg_read) begin
      case (reg_addr)
        port_reset_pkg::BRIDGE_CTL_OFS:
          s_d.rdata = put_bit(s_q.bridge_sbr, port_reset_pkg::SBR_BIT);
        port_reset_pkg::SWITCH_CTL_OFS:
          s_d.rdata = put_bit(s_q.up_sbr, port_reset_pkg::UP_SBR_BIT);
        port_reset_pkg::SLOT_CTL_OFS:
          s_d.rdata = put_bit(s_q.pwr_off, port_reset_pkg::PWR_OFF_BIT);
        port_reset_pkg::HP_CFG_OFS: begin
          s_d.rdata = put_bit(s_q.rst_oe, port_reset_pkg::RST_OE_BIT);
          s_d.rdata[port_reset_pkg::MODE_LSB +: 2] = s_q.mode;
          s_d.rdata[port_reset_pkg::P2R_LSB +: 8]  = s_q.p2r;
          s_d.rdata[port_reset_pkg::R2P_LSB +: 8]  = s_q.r2p;
        end
        port_reset_pkg::STATUS_OFS:
          s_d.rdata =
            put_bit(s_q.sbr != SBR_IDLE, port_reset_pkg::ST_SBR_BIT)
            | put_bit(s_q.rst_on, port_reset_pkg::ST_RST_BIT)
            | put_bit(s_q.pe, port_reset_pkg::ST_PE_BIT)
            | put_bit(!pg_n_sync, port_reset_pkg::ST_PG_BIT)
            | put_bit(link_up, port_reset_pkg::ST_LINK_BIT)
            | put_bit(dly_busy || pulse_busy, port_reset_pkg::ST_BUSY_BIT);
        default:
          s_d.rdata = 32'h0000_0000; // unmapped reads as zero
      endcase
    end

    // secondary bus reset sequence, local to this port only
    case (s_q.sbr)
      SBR_IDLE: begin
        if (wr_hit(port_reset_pkg::BRIDGE_CTL_OFS)
            && reg_wdata[port_reset_pkg::SBR_BIT]) begin
          s_d.sbr = SBR_HOT;
        end
      end
      SBR_HOT: begin
        s_d.sbr = SBR_FLUSH;
      end
      SBR_FLUSH: begin
        if (flush_done) begin
          s_d.sbr = SBR_WAIT;
        end
      end
      SBR_WAIT: begin
        if (!s_q.up_sbr) begin
          s_d.sbr = SBR_IDLE;
        end
      end
      default: s_d.sbr = SBR_IDLE;
    endcase
    // hot reset sets only with the link up, one request per reset
    s_d.hot   = (s_d.sbr == SBR_HOT) && link_up;
    s_d.flush = (s_d.sbr == SBR_FLUSH);
    // config path untouched; only secondary side traffic is refused
    s_d.ur    = (s_d.sbr != SBR_IDLE);

    // slot power sequence
    case (s_q.pwr)
      PWR_OFF: begin
        s_d.pe = 1'b0;
        if (!s_q.pwr_off) begin
          s_d.pe = 1'b1;
          if (s_q.mode == port_reset_pkg::MODE_PWR_GD) begin
            s_d.pwr = PWR_WAIT_GOOD;
          end else begin
            s_d.pwr       = PWR_ON_DLY;
            s_d.dly_start = 1'b1;
            s_d.dly_val   = s_q.p2r;
          end
        end
      end
      PWR_WAIT_GOOD: begin
        if (s_q.pwr_off) begin
          s_d.pwr       = PWR_OFF_DLY;
          s_d.dly_start = 1'b1;
          s_d.dly_val   = s_q.r2p;
        end else if (!pg_n_sync) begin
          s_d.pwr       = PWR_ON_DLY;
          s_d.dly_start = 1'b1;
          s_d.dly_val   = s_q.p2r;
        end
      end
      PWR_ON_DLY: begin
        if (s_q.pwr_off) begin
          s_d.pwr       = PWR_OFF_DLY;
          s_d.dly_start = 1'b1;
          s_d.dly_val   = s_q.r2p;
        end else if (s_q.mode == port_reset_pkg::MODE_PWR_GD
                     && pg_n_sync) begin
          s_d.pwr = PWR_WAIT_GOOD;
        end else if (!s_q.dly_start && !dly_busy) begin
          s_d.pwr = PWR_ON;
        end
      end
      PWR_ON: begin
        if (s_q.pwr_off) begin
          s_d.pwr       = PWR_OFF_DLY;
          s_d.dly_start = 1'b1;
          s_d.dly_val   = s_q.r2p;
        end else if (s_q.mode == port_reset_pkg::MODE_PWR_GD
                     && pg_n_sync) begin
          s_d.pwr = PWR_WAIT_GOOD;
        end
      end
      PWR_OFF_DLY: begin
        // drop power once reset is asserted and the delay runs out
        if (!s_q.dly_start && !dly_busy && s_q.rst_on) begin
          s_d.pwr = PWR_OFF;
          s_d.pe  = 1'b0;
        end
      end
      default: s_d.pwr = PWR_OFF;
    endcase
    if (s_q.mode == port_reset_pkg::MODE_HOT_RST) begin
      // no sequencing: power follows the control bit directly
      s_d.pe  = !s_q.pwr_off;
      s_d.pwr = s_q.pwr_off ? PWR_OFF : PWR_ON;
    end

    // reset output with minimum pulse width
    if (want_rst && !s_q.rst_on) begin
      s_d.rst_on      = 1'b1;
      s_d.pulse_start = 1'b1;
    end else if (!want_rst && s_q.rst_on
                 && !s_q.pulse_start && !pulse_busy) begin
      s_d.rst_on = 1'b0;
    end
    // power good loss drives reset at once, no waiting
    if (s_q.mode == port_reset_pkg::MODE_PWR_GD && s_q.pwr == PWR_ON
        && pg_n_sync && !s_q.rst_on) begin
      s_d.rst_on      = 1'b1;
      s_d.pulse_start = 1'b1;
    end

    // pin stays undriven until software enables the reset function
    s_d.oe = s_q.rst_oe;
    s_d.rst_n = !s_d.rst_on; // pin level kept in its own flop
  end

  // state register
  always_ff @(posedge clock) begin
    if (rst) begin
      s_q <= '{
        bridge_sbr:  1'b0,
        up_sbr:      1'b0,
        pwr_off:     port_reset_pkg::PWR_OFF_RST,
        mode:        port_reset_pkg::MODE_RST,
        p2r:         port_reset_pkg::P2R_RST,
        r2p:         port_reset_pkg::R2P_RST,
        rst_oe:      1'b0,
        sbr:         SBR_IDLE,
        pwr:         PWR_OFF,
        pre:         6'h00,
        us_tick:     1'b0,
        dly_start:   1'b0,
        dly_val:     8'h00,
        pulse_start: 1'b0,
        rst_on:      1'b1,
        rst_n:       1'b0,
        pe:          1'b0,
        hot:         1'b0,
        flush:       1'b0,
        ur:          1'b0,
        oe:          1'b0,
        rdata:       32'h0000_0000
      };
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from the state register
  assign reg_rdata             = s_q.rdata;
  assign send_hot_reset        = s_q.hot;
  assign flush_tlps            = s_q.flush;
  assign secondary_ur          = s_q.ur;
  assign slot_power_enable_out = s_q.pe;
  assign port_reset_out_n_o    = s_q.rst_n;
  assign port_reset_out_n_oe   = s_q.oe;
endmodule // downstream_port_reset_sequencer
`default_nettype wire

// *** port_reset_assertions.sv ***
// concurrent checks on the port reset sequencer ports
`default_nettype none
module port_reset_assertions #(
  parameter int unsigned MIN_PULSE_CYCLES = 20
) (
  // clock and reset
  input wire logic        clock,
  input wire logic        rst,
  // register port
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_write,
  input wire logic        reg_read,
  input wire logic [31:0] reg_rdata,
  // link and queue side
  input wire logic        link_up,
  input wire logic        flush_done,
  input wire logic        send_hot_reset,
  input wire logic        flush_tlps,
  input wire logic        secondary_ur,
  // slot pins
  input wire logic        slot_power_good_n,
  input wire logic        slot_power_enable_out,
  input wire logic        port_reset_out_n_o,
  input wire logic        port_reset_out_n_oe
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  logic [1:0]  mode_q;
  logic        up_q;
  logic        arm_q;
  logic [15:0] low_q;
  // shadow of mode and upstream bit, low time of a fresh pulse
  always_ff @(posedge clock) begin
    if (rst) begin
      mode_q <= port_reset_pkg::MODE_RST;
      up_q   <= 1'b0;
      arm_q  <= 1'b0;
      low_q  <= 16'h0000;
    end else begin
      if (reg_write && reg_addr == port_reset_pkg::HP_CFG_OFS)
        mode_q <= reg_wdata[1:0];
      if (reg_write && reg_addr == port_reset_pkg::SWITCH_CTL_OFS)
        up_q <= reg_wdata[port_reset_pkg::UP_SBR_BIT];
      if (port_reset_out_n_o) begin
        low_q <= 16'h0000;
        arm_q <= 1'b1;
      end else if (low_q != 16'hffff) begin
        low_q <= low_q + 16'h0001;
      end
    end
  end
  a_oe_undriven: assert property (
    $fell(rst) |-> !port_reset_out_n_oe && !slot_power_enable_out)
    else $error("reset pin or power driven after reset");
  a_hot_pulse: assert property (
    send_hot_reset |-> $past(link_up) && $rose(secondary_ur)
      ##1 !send_hot_reset)
    else $error("hot reset request without start or link");
  a_sbr_start: assert property (
    $rose(secondary_ur) |-> $past(reg_write && reg_wdata[0]
      && reg_addr == port_reset_pkg::BRIDGE_CTL_OFS) ##1 flush_tlps)
    else $error("secondary reset start mismatch");
  a_flush_scope: assert property (
    flush_tlps |-> secondary_ur)
    else $error("flush outside secondary reset");
  a_flush_end: assert property (
    flush_tlps && flush_done |=> !flush_tlps)
    else $error("flush not ended after done");
  a_sbr_hold: assert property (
    $fell(secondary_ur) |-> !$past(up_q))
    else $error("resumed while upstream bit set");
  a_min_pulse: assert property (
    $rose(port_reset_out_n_o) |-> !arm_q || low_q >= MIN_PULSE_CYCLES)
    else $error("reset pulse too short");
  a_off_order: assert property (
    $fell(slot_power_enable_out) && mode_q != port_reset_pkg::MODE_HOT_RST
      |-> !port_reset_out_n_o && $past(!port_reset_out_n_o))
    else $error("power dropped before reset");
  a_on_order: assert property (
    $rose(port_reset_out_n_o) && mode_q != port_reset_pkg::MODE_HOT_RST
      |-> slot_power_enable_out && $past(slot_power_enable_out))
    else $error("reset released without power");
  a_pg_wait: assert property (
    $rose(port_reset_out_n_o) && mode_q == port_reset_pkg::MODE_PWR_GD
      |-> !$past(slot_power_good_n, 2))
    else $error("reset released before power good");
  a_pg_loss: assert property (
    mode_q == port_reset_pkg::MODE_PWR_GD && port_reset_out_n_o
      && $rose(slot_power_good_n) |-> ##[1:5] !port_reset_out_n_o)
    else $error("power fault did not assert reset");
  a_hot_mode: assert property (
    mode_q == port_reset_pkg::MODE_HOT_RST && $rose(secondary_ur)
      |-> ##[0:2] !port_reset_out_n_o)
    else $error("hot reset mode did not assert reset");
endmodule // port_reset_assertions
`default_nettype wire

// *** slot_power_model.sv ***
// slot with power supply and a pull-down on the reset line
`default_nettype none
module slot_power_model #(
  parameter int GOOD_DLY = 600
) (
  // clock
  input  wire logic clock,
  // from the sequencer
  input  wire logic power_en,
  input  wire logic rst_n_o,
  input  wire logic rst_n_oe,
  // fault injection from the bench
  input  wire logic fault,
  // to the sequencer and the bench
  output wire logic power_good_n,
  output wire logic reset_pin
);
  int ramp_q;
  // supply ramp after enable
  always_ff @(posedge clock) begin
    if (!power_en) ramp_q <= 0;
    else if (ramp_q < GOOD_DLY) ramp_q <= ramp_q + 1;
  end
  // not good while off, ramping or faulted
  assign power_good_n = !(power_en && ramp_q >= GOOD_DLY && !fault);
  assign reset_pin = rst_n_oe ? rst_n_o : 1'b0;
endmodule // slot_power_model
`default_nettype wire

// *** tb_top.sv ***
// self-checking bench for the port reset sequencer
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned MINP = 400;
  localparam logic [7:0] BRC = port_reset_pkg::BRIDGE_CTL_OFS;
  localparam logic [7:0] SWC = port_reset_pkg::SWITCH_CTL_OFS;
  localparam logic [7:0] SLC = port_reset_pkg::SLOT_CTL_OFS;
  localparam logic [7:0] HPC = port_reset_pkg::HP_CFG_OFS;
  localparam logic [7:0] STA = port_reset_pkg::STATUS_OFS;
  logic        clock, rst, reg_write, reg_read;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic        link_up, flush_done, send_hot_reset, flush_tlps;
  logic        secondary_ur, slot_power_good_n, slot_power_enable_out;
  logic        port_reset_out_n_o, port_reset_out_n_oe, reset_pin, fault;
  int          error_cnt, comparisons, hot_cnt;
  downstream_port_reset_sequencer #(.MIN_PULSE_CYCLES(MINP)) uut (
    .clock(clock), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .link_up(link_up), .flush_done(flush_done),
    .send_hot_reset(send_hot_reset), .flush_tlps(flush_tlps),
    .secondary_ur(secondary_ur), .slot_power_good_n(slot_power_good_n),
    .slot_power_enable_out(slot_power_enable_out),
    .port_reset_out_n_o(port_reset_out_n_o),
    .port_reset_out_n_oe(port_reset_out_n_oe));
  slot_power_model #(.GOOD_DLY(600)) slot (
    .clock(clock), .power_en(slot_power_enable_out),
    .rst_n_o(port_reset_out_n_o), .rst_n_oe(port_reset_out_n_oe),
    .fault(fault), .power_good_n(slot_power_good_n),
    .reset_pin(reset_pin));
  // clock and hot reset request counter
  always #10 clock = ~clock;
  always @(posedge clock) if (send_hot_reset === 1'b1) hot_cnt++;
  task automatic tally_and_finish();
    if (error_cnt == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chb(input string nm, input logic e, g);
    chk(nm, {31'h0, e}, {31'h0, g});
  endtask
  // one-cycle register write and read
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_write <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clock);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_read <= 1'b0;
    @(negedge clock);
    chk("reg_rdata", e, reg_rdata);
  endtask
  function automatic logic pick(input int s);
    case (s)
      0: return slot_power_enable_out;
      1: return port_reset_out_n_o;
      default: return secondary_ur;
    endcase
  endfunction
  // bounded wait for a level, n counts cycles waited
  task automatic wt(input int s, input logic v, output int n);
    n = 0;
    while (pick(s) !== v && n < 2000) begin
      @(negedge clock);
      n++;
    end
    chb("wait level", v, pick(s));
  endtask
  // watchdog
  initial begin
    repeat (30000) @(posedge clock);
    error_cnt++;
    tally_and_finish();
  end
  initial begin
    int n;
    int m;
    clock       = 0;
    rst         = 1;
    reg_write   = 0;
    reg_read    = 0;
    reg_addr    = 0;
    reg_wdata   = 0;
    link_up     = 1;
    flush_done  = 0;
    fault       = 0;
    error_cnt   = 0;
    comparisons = 0;
    hot_cnt     = 0;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    @(negedge clock);
    chb("oe", 0, port_reset_out_n_oe);
    chb("pin", 0, reset_pin);
    chb("power", 0, slot_power_enable_out);
    rd(HPC, 32'h000a_0a00);
    rd(SLC, 32'h0000_0001);
    rd(STA, 32'h0000_0012);
    wr(8'h20, 32'hffff_ffff);
    rd(8'h20, 32'h0000_0000);
    // power enable mode, one microsecond delays, pin driven
    wr(HPC, 32'h0101_0100);
    @(negedge clock);
    chb("pin", 0, reset_pin);
    wr(SLC, 32'h0000_0000);
    wt(0, 1, n);
    chb("reset", 0, port_reset_out_n_o);
    wt(1, 1, n);
    chb("pin", 1, reset_pin);
    rd(STA, 32'h0000_0014);
    wr(SLC, 32'h0000_0001);
    wt(1, 0, n);
    chb("power", 1, slot_power_enable_out);
    wt(0, 0, n);
    // mode 3 acts as power enable; zero power delay, pulse stretched
    wr(HPC, 32'h0101_0003);
    wr(SLC, 32'h0000_0000);
    wt(1, 1, m);
    chb("pulse", 1, n + m + 4 >= MINP);
    // power good mode with a slow supply, then a fault
    wr(SLC, 32'h0000_0001);
    wt(0, 0, n);
    wr(HPC, 32'h0101_0101);
    wr(SLC, 32'h0000_0000);
    wt(0, 1, n);
    wt(1, 1, m);
    chb("after good", 1, m >= 600);
    @(posedge clock) fault <= 1'b1;
    wt(1, 0, n);
    chb("fault fast", 1, n <= 6);
    @(posedge clock) fault <= 1'b0;
    wr(SLC, 32'h0000_0001);
    wt(0, 0, n);
    // hot reset mode and a secondary bus reset
    wr(HPC, 32'h0101_0102);
    wr(SLC, 32'h0000_0000);
    wt(1, 1, n);
    wr(SWC, 32'h0000_0001);
    wr(BRC, 32'h0000_0001);
    @(negedge clock);
    chb("ur", 1, secondary_ur);
    @(negedge clock);
    chb("flush", 1, flush_tlps);
    @(negedge clock);
    chb("reset", 0, port_reset_out_n_o);
    chb("power", 1, slot_power_enable_out);
    rd(HPC, 32'h0101_0102);
    @(posedge clock) flush_done <= 1'b1;
    @(posedge clock) flush_done <= 1'b0;
    @(negedge clock);
    chb("flush", 0, flush_tlps);
    repeat (5) @(negedge clock);
    chb("ur held", 1, secondary_ur);
    wr(SWC, 32'h0000_0000);
    wt(2, 0, n);
    chb("resume", 1, n <= 3);
    wt(1, 1, m);
    chk("hot count", 1, hot_cnt);
    // link down: no hot reset request
    wr(BRC, 32'h0000_0000);
    @(posedge clock) link_up <= 1'b0;
    wr(BRC, 32'h0000_0001);
    @(posedge clock) flush_done <= 1'b1;
    wt(2, 0, n);
    @(posedge clock) flush_done <= 1'b0;
    chk("hot count", 1, hot_cnt);
    tally_and_finish();
  end
endmodule // tb_top
bind downstream_port_reset_sequencer port_reset_assertions #(
  .MIN_PULSE_CYCLES(MIN_PULSE_CYCLES)
) chk_i (
  .clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
  .link_up(link_up), .flush_done(flush_done),
  .send_hot_reset(send_hot_reset), .flush_tlps(flush_tlps),
  .secondary_ur(secondary_ur), .slot_power_good_n(slot_power_good_n),
  .slot_power_enable_out(slot_power_enable_out),
  .port_reset_out_n_o(port_reset_out_n_o),
  .port_reset_out_n_oe(port_reset_out_n_oe));
`default_nettype wire
